// File: hw/sps_pin_if.sv
// Synchronised pin levels passed from the synchroniser to the shifter core
`timescale 1ns/100ps
interface sps_pin_if;
    logic       capture_select;                             // High shifts, low captures
    logic       shift_clk;                                  // Shift clock pin level
    logic       edge_block;                                 // Clock block pin level
    logic       serial_in;                                  // Serial data pin level
    logic [7:0] taps;                                       // Parallel taps A..H

    // Synchroniser drives, core reads
    modport src (output capture_select, shift_clk, edge_block, serial_in, taps);
    modport dst (input  capture_select, shift_clk, edge_block, serial_in, taps);
endinterface

// File: hw/sps_pin_sync.sv
// Two-flop synchroniser for all shifter pins
`timescale 1ns/100ps
module sps_pin_sync (
    input  wire logic       i_sys_clk,                      // System clock
    input  wire logic       i_sys_rst,                      // Async reset, active high
    input  wire logic       i_capture_select,               // Raw capture select pin
    input  wire logic       i_shift_clk,                    // Raw shift clock pin
    input  wire logic       i_edge_block,                   // Raw edge block pin
    input  wire logic       i_serial_in,                    // Raw serial input pin
    input  wire logic [7:0] i_taps,                         // Raw taps A..H
    sps_pin_if.src          pins                            // Synchronised levels
);
    import sps_pkg::*;

    sps_sync_state_t st;                                    // Present ranks
    sps_sync_state_t next_st;                               // Next ranks

    // First rank takes pins, second rank takes first rank only
    always_comb begin
        next_st.cap   = {st.cap[0], i_capture_select};
        next_st.clk   = {st.clk[0], i_shift_clk};
        next_st.blk   = {st.blk[0], i_edge_block};
        next_st.ser   = {st.ser[0], i_serial_in};
        next_st.tap_a = i_taps;
        next_st.tap_b = st.tap_a;
    end

    // Register all ranks
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Only second ranks leave this module
    assign pins.capture_select = st.cap[1];
    assign pins.shift_clk      = st.clk[1];
    assign pins.edge_block     = st.blk[1];
    assign pins.serial_in      = st.ser[1];
    assign pins.taps           = st.tap_b;

endmodule // sps_pin_sync

// File: hw/sps_pkg.sv
// Constants and types shared by the parallel-in serial-out shifter
// Functional notes
// [R1] Eight stages form one parallel/serial shift chain
// [R2] Capture select low loads taps A-H continuously
// [R3] Tap changes reach stages without shift edges
// [R4] During capture, outputs follow tap H and complement
// [R5] Select high without edge keeps all stages
// [R6] Shift edge: serial in to first, rest advance
// [R7] Old last-stage value is dropped on shift
// [R8] Outputs always show last stage and complement
// [R9] Edge block high suppresses shifts from clock
// [R10] Clock and edge block inputs are interchangeable
// [R11] No documented power-up value; controller loads first
// [R12] Shift on rising edge of clock OR block
package sps_pkg;

    localparam int unsigned SPS_STAGES     = 8;            // Length of shift chain
    localparam int unsigned SPS_SYNC_DEPTH = 2;            // Flops per pin synchroniser
    localparam logic [7:0]  SPS_STAGE_RST  = 8'h00;        // Chain value after reset
    localparam logic        SPS_BIT_RST    = 1'h0;         // Single flop value after reset

    // Synchroniser state: two ranks per pin
    typedef struct packed {
        logic [1:0] cap;                                    // Capture select ranks
        logic [1:0] clk;                                    // Shift clock pin ranks
        logic [1:0] blk;                                    // Edge block ranks
        logic [1:0] ser;                                    // Serial input ranks
        logic [7:0] tap_a;                                  // First rank of taps
        logic [7:0] tap_b;                                  // Second rank of taps
    } sps_sync_state_t;

    // Core state of the shifter
    typedef struct packed {
        logic [7:0] stage;                                  // Chain, bit 0 first, bit 7 last
        logic       gated_prev;                             // Last gated clock level
        logic       out_true;                               // Registered serial output
        logic       out_inv;                                // Registered inverted output
    } sps_core_state_t;

endpackage

// File: hw/sps_shifter.sv
// Eight-stage parallel-in serial-out shift register, top level
`timescale 1ns/100ps
module sps_shifter (
    input  wire logic       i_sys_clk,                      // System clock, 20 MHz
    input  wire logic       i_sys_rst,                      // Async reset, active high
    input  wire logic       i_capture_select,               // Low captures taps, high shifts
    input  wire logic       i_shift_clk,                    // Shift clock pin
    input  wire logic       i_edge_block,                   // Clock block pin
    input  wire logic       i_serial_in,                    // Serial data into first stage
    input  wire logic [7:0] i_taps,                         // Parallel taps, bit 0 = A
    output logic            o_serial_out,                   // Last stage
    output logic            o_serial_out_n                  // Complement of last stage
);
    import sps_pkg::*;

    sps_pin_if       pins ();                               // Synchronised pin levels
    sps_core_state_t st;                                    // Present core state
    sps_core_state_t next_st;                               // Next core state
    logic            gated;                                 // Clock OR block
    logic            shift_ev;                              // One-cycle shift event

    // Every pin passes two flops before the core looks at it
    sps_pin_sync u_sync (
        .i_sys_clk        (i_sys_clk),
        .i_sys_rst        (i_sys_rst),
        .i_capture_select (i_capture_select),
        .i_shift_clk      (i_shift_clk),
        .i_edge_block     (i_edge_block),
        .i_serial_in      (i_serial_in),
        .i_taps           (i_taps),
        .pins             (pins)
    );

    // Either input high masks edges on the other
    assign gated    = pins.shift_clk | pins.edge_block;                 // [R12] [R10] [R9]
    assign shift_ev = pins.capture_select & gated & ~st.gated_prev;     // [R12]

    // Next state of chain and outputs
    always_comb begin
        next_st            = st;
        next_st.gated_prev = gated;
        if (!pins.capture_select) begin
            // Capture: taps overwrite every stage each cycle
            next_st.stage = pins.taps;                                  // [R2] [R3] [R1]
        end else if (shift_ev) begin
            // Shift: serial in enters, bit 7 falls off the end
            next_st.stage = {st.stage[6:0], pins.serial_in};            // [R6] [R7] [R1]
        end else begin
            // No edge: chain holds
            next_st.stage = st.stage;                                   // [R5]
        end
        // Outputs mirror the new last stage in the same cycle
        next_st.out_true = next_st.stage[SPS_STAGES-1];                 // [R8] [R4]
        next_st.out_inv  = ~next_st.stage[SPS_STAGES-1];                // [R8] [R4]
    end

    // Register core state; reset gives a defined start value
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st.stage      <= SPS_STAGE_RST;                             // [R11]
            st.gated_prev <= SPS_BIT_RST;
            st.out_true   <= SPS_BIT_RST;
            st.out_inv    <= ~SPS_BIT_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign o_serial_out   = st.out_true;
    assign o_serial_out_n = st.out_inv;

    // Capture loads taps one cycle later
    load_follow_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R2]
        !pins.capture_select |=> st.stage == $past(pins.taps))
        else $error("stages did not follow taps in capture");

    // Tap change in capture reaches stage without any shift edge
    tap_async_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R3]
        (!pins.capture_select && !gated && $changed(pins.taps))
        |=> st.stage == $past(pins.taps))
        else $error("tap change lost while capturing");

    // Capture outputs show tap H and its complement
    load_out_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R4]
        !pins.capture_select |=> (o_serial_out == $past(pins.taps[7]))
        && (o_serial_out_n == !$past(pins.taps[7])))
        else $error("capture outputs not tap H");

    // No edge means no change
    hold_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R5]
        (pins.capture_select && !(gated && !st.gated_prev)) |=> $stable(st.stage))
        else $error("stages changed without shift edge");

    // Shift moves chain one place and drops the last bit
    shift_step_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R6] [R7]
        shift_ev |=> st.stage == {$past(st.stage[6:0]), $past(pins.serial_in)})
        else $error("shift step wrong");

    // Outputs always track last stage
    out_match_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R8]
        (o_serial_out == st.stage[7]) && (o_serial_out_n != o_serial_out))
        else $error("outputs differ from last stage");

    // Clock edges under a held block do nothing
    block_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R9]
        (pins.capture_select && pins.edge_block && $past(pins.edge_block))
        |=> $stable(st.stage))
        else $error("shift while edge block high");

    // Block rising with clock low acts as a shift
    block_edge_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R10]
        (pins.capture_select && !pins.shift_clk && !$past(pins.shift_clk)
        && $rose(pins.edge_block))
        |=> st.stage == {$past(st.stage[6:0]), $past(pins.serial_in)})
        else $error("edge block rise did not shift");

    // Clock rising while block high gives no shift
    or_edge_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst) // [R12]
        ($rose(pins.shift_clk) && $past(pins.edge_block) && pins.edge_block)
        |-> !shift_ev)
        else $error("masked clock edge shifted");

endmodule // sps_shifter

// File: tb/sps_ctrl_model.sv
// Controller model driving the shifter pins and reading the serial output
`timescale 1ns/100ps
module sps_ctrl_model (
    input  wire logic       i_sys_clk,                      // System clock
    input  wire logic       i_serial_out,                   // Serial output of the shifter
    output logic            o_capture_select,               // Low captures, high shifts
    output logic            o_shift_clk,                    // Shift clock line
    output logic            o_edge_block,                   // Clock block line
    output logic            o_serial_in,                    // Serial data line
    output logic [7:0]      o_taps                          // Parallel taps A..H
);
    // Last level seen on the serial output
    logic                   seen_bit;

    // Quiet pins at time zero: capture mode, no edges
    initial begin
        o_capture_select = 1'h0;
        o_shift_clk      = 1'h0;
        o_edge_block     = 1'h0;
        o_serial_in      = 1'h0;
        o_taps           = 8'h00;
        seen_bit         = 1'h0;
    end

    // Set all pins on a falling edge, hold each level well past the sync latency
    task automatic drive(input logic cap, input logic clk, input logic blk,
                         input logic ser, input logic [7:0] taps);
        @(negedge i_sys_clk);
        o_capture_select = cap;
        o_shift_clk      = clk;
        o_edge_block     = blk;                             // Raised to mask clock
        o_serial_in      = ser;
        o_taps           = taps;
        repeat (4) @(negedge i_sys_clk);
        seen_bit         = i_serial_out;
    endtask
endmodule // sps_ctrl_model

// File: tb/sps_shifter_tb_top.sv
// Self-checking bench for the parallel-in serial-out shifter
`timescale 1ns/100ps
`define SPS_CHECK(got, want) begin tests_run++; if ((got) !== (want)) begin n_errors++; $display("wrong value at %0t: output mismatch", $time); end end
module sps_shifter_tb_top;
    logic       i_sys_clk = 1'h0;                           // 20 MHz clock
    logic       i_sys_rst = 1'h1;                           // Reset, active high
    logic       cap, sclk, blk, ser;                        // Pins from the model
    logic [7:0] taps;                                       // Taps from the model
    logic       o_serial_out, o_serial_out_n;               // Shifter outputs
    logic [7:0] exp;                                        // Expected chain content
    logic [7:0] got = 8'h00;                                // Bits seen on the serial output
    int         n_errors = 0;                               // Mismatch count
    int         tests_run = 0;                              // Comparison count
    int         cycles = 0;                                 // Timeout counter

    // Clock generator
    always #25 i_sys_clk = ~i_sys_clk;

    sps_ctrl_model i_sps_ctrl_model (.i_sys_clk(i_sys_clk), .i_serial_out(o_serial_out),
        .o_capture_select(cap), .o_shift_clk(sclk), .o_edge_block(blk),
        .o_serial_in(ser), .o_taps(taps));
    sps_shifter i_sps_shifter (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
        .i_capture_select(cap), .i_shift_clk(sclk), .i_edge_block(blk),
        .i_serial_in(ser), .i_taps(taps), .o_serial_out(o_serial_out),
        .o_serial_out_n(o_serial_out_n));

    // Compare both outputs with the expected last stage
    task automatic check_out();
        `SPS_CHECK(o_serial_out, exp[7])
        `SPS_CHECK(o_serial_out_n, ~exp[7])
    endtask

    // Capture follows taps with no shift edge; edges ignored while capturing
    task automatic test_capture();
        i_sps_ctrl_model.drive(1'h0, 1'h0, 1'h0, 1'h0, 8'hA5);
        exp = 8'hA5;
        check_out();
        i_sps_ctrl_model.drive(1'h0, 1'h0, 1'h0, 1'h0, 8'h25);
        exp = 8'h25;
        check_out();
        i_sps_ctrl_model.drive(1'h0, 1'h1, 1'h0, 1'h1, 8'h25);
        i_sps_ctrl_model.drive(1'h0, 1'h0, 1'h0, 1'h1, 8'hA5);
        exp = 8'hA5;
        check_out();
    endtask

    // Load, hold, then shift eight bits out while taps change
    task automatic test_shift();
        i_sps_ctrl_model.drive(1'h0, 1'h0, 1'h0, 1'h0, 8'hB4);
        i_sps_ctrl_model.drive(1'h1, 1'h0, 1'h0, 1'h0, 8'h4B);
        exp = 8'hB4;
        check_out();
        for (int i = 0; i < 8; i++) begin
            // Collect the bit the shifter shows before each shift
            got = {got[6:0], o_serial_out};
            i_sps_ctrl_model.drive(1'h1, 1'h1, 1'h0, i[0], 8'h00);
            exp = {exp[6:0], i[0]};
            check_out();
            i_sps_ctrl_model.drive(1'h1, 1'h0, 1'h0, i[0], 8'hFF);
            check_out();
        end
        `SPS_CHECK(got, 8'hB4)
    endtask

    // Block line as clock, block masking, and the OR-gated edge
    task automatic test_block();
        i_sps_ctrl_model.drive(1'h1, 1'h0, 1'h1, 1'h1, 8'h00);
        exp = {exp[6:0], 1'h1};
        check_out();
        i_sps_ctrl_model.drive(1'h1, 1'h1, 1'h1, 1'h0, 8'h00);
        i_sps_ctrl_model.drive(1'h1, 1'h0, 1'h1, 1'h0, 8'h00);
        i_sps_ctrl_model.drive(1'h1, 1'h0, 1'h0, 1'h0, 8'h00);
        check_out();
        i_sps_ctrl_model.drive(1'h1, 1'h1, 1'h0, 1'h1, 8'h00);
        exp = {exp[6:0], 1'h1};
        check_out();
        i_sps_ctrl_model.drive(1'h1, 1'h1, 1'h1, 1'h0, 8'h00);
        i_sps_ctrl_model.drive(1'h1, 1'h1, 1'h0, 1'h0, 8'h00);
        i_sps_ctrl_model.drive(1'h1, 1'h0, 1'h0, 1'h0, 8'h00);
        check_out();
    endtask

    // Print counts and verdict, then end the run
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Cut a hang short
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            test_done();
        end
    end

    // Main sequence: reset, then scenarios
    initial begin
        repeat (5) @(negedge i_sys_clk);
        i_sys_rst = 1'h0;
        test_capture();
        test_shift();
        test_block();
        test_done();
    end
endmodule // sps_shifter_tb_top
